// file: hdl/lro_pkg.sv
package lro_pkg;

  // Timing base
  localparam int LRO_CLK_HZ = 50_000_000;
  localparam int LRO_TICK_MS = 100;
  localparam int LRO_TICK_CYCLES = LRO_CLK_HZ / 1000 * LRO_TICK_MS;
  localparam int LRO_TICKS_PER_S = 1000 / LRO_TICK_MS;
  localparam int LRO_BLINK_HALF_MS = 500;
  localparam int LRO_BLINK_TICKS = LRO_BLINK_HALF_MS / LRO_TICK_MS;
  localparam int LRO_WIN_MIN_MS = 500;
  localparam int LRO_WIN_MAX_MS = 5000;
  localparam int LRO_WIN_MIN_TICKS = (LRO_WIN_MIN_MS + LRO_TICK_MS - 1) / LRO_TICK_MS;
  localparam int LRO_WIN_MAX_TICKS = LRO_WIN_MAX_MS / LRO_TICK_MS;
  localparam int LRO_PULSE_MIN_S = 6;
  localparam int LRO_PULSE_MAX_S = 120;
  localparam int LRO_NV_WR_MS = 50;
  localparam int LRO_NV_WR_CYCLES = LRO_CLK_HZ / 1000 * LRO_NV_WR_MS;
  localparam int LRO_NV_WR_LIMIT = 100_000;

  // Operator counts
  localparam int LRO_SR_NUM = 4;
  localparam int LRO_RETAIN_MAX = 8;
  localparam int LRO_IR_NUM = 4;
  localparam int LRO_GATE_IN = 7;
  localparam logic [3:0] LRO_IR_MONITORED = 4'ha;

  // Register offsets
  localparam logic [11:0] LRO_OFS_CTRL = 12'h000;
  localparam logic [11:0] LRO_OFS_RETAIN = 12'h004;
  localparam logic [11:0] LRO_OFS_MACRO = 12'h008;
  localparam logic [11:0] LRO_OFS_PRE = 12'h00c;
  localparam logic [11:0] LRO_OFS_STATUS = 12'h010;
  localparam logic [11:0] LRO_OFS_NV = 12'h014;

  typedef enum logic [2:0] {
    LRO_G_AND = 3'b000,
    LRO_G_NAND = 3'b001,
    LRO_G_OR = 3'b010,
    LRO_G_NOR = 3'b011,
    LRO_G_XOR = 3'b100,
    LRO_G_XNOR = 3'b101
  } lro_gate_t;

  typedef enum logic [2:0] {
    LRO_PR_IDLE = 3'b000,
    LRO_PR_B1 = 3'b001,
    LRO_PR_WAIT = 3'b010,
    LRO_PR_B2 = 3'b011,
    LRO_PR_DONE = 3'b100
  } lro_pr_state_t;

  typedef struct packed {
    logic [10:0] rsvd;
    logic m2_out_en;
    logic m1_out_en;
    logic pr_intr_en;
    logic pr_wait_en;
    logic pr_clr_en;
    logic [3:0] ir_style2;
    logic [3:0] ir_req_en;
    logic [3:0] ir_clr_en;
    logic sr_clr_en;
    logic t_clr_en;
    logic d_clr_en;
    logic d_pre_en;
  } lro_ctrl_t;

  typedef struct packed {
    lro_gate_t rst_type;
    logic [2:0] rst_cnt;
    lro_gate_t in_type;
    logic [2:0] in_cnt;
  } lro_mcfg_t;

  typedef struct packed {
    logic [7:0] rsvd;
    lro_mcfg_t [1:0] m;
  } lro_mreg_t;

  typedef struct packed {
    logic [20:0] rsvd;
    logic [2:0] intr_lim;
    logic rsvd_b;
    logic [6:0] max_s;
  } lro_prcfg_t;

  typedef struct packed {
    logic d_smp;
    logic d_ck;
    logic d_pre;
    logic d_clr;
    logic t_tgl;
    logic t_clr;
    logic [LRO_SR_NUM-1:0] sr_set;
    logic [LRO_SR_NUM-1:0] sr_rst;
    logic [LRO_SR_NUM-1:0] sr_clr;
    logic [1:0] ir_in;
    logic [1:0] ir_rst;
    logic [LRO_IR_NUM-1:0] ir_clr;
    logic [1:0][LRO_GATE_IN-1:0] m_in;
    logic [1:0][LRO_GATE_IN-1:0] m_rst;
    logic pr_b1;
    logic pr_b2;
    logic pr_clr;
  } lro_in_t;

  typedef struct packed {
    logic d_q;
    logic t_q;
    logic [LRO_SR_NUM-1:0] sr_q;
    logic [LRO_IR_NUM-1:0] ir_q;
    logic [LRO_IR_NUM-1:0] ir_req;
    logic [1:0] m_gate;
    logic pr_q;
    logic pr_wait;
  } lro_out_t;

  // Reset values
  localparam lro_ctrl_t LRO_CTRL_RST = lro_ctrl_t'(32'h0000_0000);
  localparam lro_mreg_t LRO_MACRO_RST = lro_mreg_t'(32'h0004_2042);
  localparam lro_prcfg_t LRO_PRE_RST = lro_prcfg_t'(32'h0000_0778);

endpackage

// file: hdl/lro_gate.sv
`timescale 1ns/10ps
module lro_gate
  import lro_pkg::*;
#(
  parameter int N = LRO_GATE_IN,
  parameter int MIN_CNT = 2
)(
  // Gate inputs
  input wire logic [N-1:0] din,
  // Configuration
  input wire logic [2:0] cnt,
  input wire lro_gate_t gtype,
  // Result
  output logic dout
);

  logic [N-1:0] mask;
  logic [2:0] eff;

  always_comb
  begin
    eff = (cnt < 3'(MIN_CNT)) ? 3'(MIN_CNT) : cnt;
    mask = '0;
    for (int i = 0; i < N; i++)
    begin
      mask[i] = (3'(i) < eff);
    end
    case (gtype)
      LRO_G_AND: dout = &(din | ~mask);
      LRO_G_NAND: dout = ~&(din | ~mask);
      LRO_G_OR: dout = |(din & mask);
      LRO_G_NOR: dout = ~|(din & mask);
      LRO_G_XOR: dout = ^(din & mask);
      LRO_G_XNOR: dout = ~^(din & mask);
      default: dout = 1'b0;
    endcase
    // A single input bypasses the gate
    if (eff == 3'd1)
    begin
      dout = din[0];
    end
  end

endmodule

// file: hdl/lro_ops.sv
`timescale 1ns/10ps
// Behaviour
// - D latch: clear forces low, preset alone high, else capture on clock rise.
// - Preset acts only when its enable is configured.
// - Every operator has an optional clear that forces its state low.
// - Toggle latch inverts on each toggle rise, otherwise holds.
// - Set/reset latch: set high, reset low, both low, neither holds.
// - Retained latches are written to storage on change, restored at power-up.
// - At most eight latches may use retention.
// - Each write takes up to 50 ms; total writes limited to 100,000.
// - Manual interlock: low on clear or input low, set on restart rise.
// - Monitored interlock sets only on complete restart pulse.
// - Request output style one or style two with 1 Hz blink.
// - Macro input gate of two to seven inputs, six gate types.
// - Macro restart gate of one to seven inputs, one input bypasses.
// - Macro may expose its input gate result.
// - Pre-reset needs pulse on button one then button two within window.
// - Pre-reset rejects pulses longer than configured 6 to 120 s.
// - Waiting output high after first pulse until second pulse ends, clear or window expiry.
// - Interruption count must be at least one and below limit up to seven.
// - Monitored restart recognised only as rise followed by fall.
module lro_ops
  import lro_pkg::*;
#(
  parameter int TICK_CYCLES = LRO_TICK_CYCLES,
  parameter int NV_WR_CYCLES = LRO_NV_WR_CYCLES,
  parameter logic [LRO_RETAIN_MAX-1:0] RETAIN_INIT = 8'h00
)(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Operator pins
  input wire lro_in_t op_in,
  output lro_out_t op_out,
  // Non-volatile store
  input wire logic [7:0] nv_rd_data,
  output logic nv_wr_req,
  output logic [7:0] nv_wr_data
);

  localparam int TICK_W = $clog2(TICK_CYCLES + 1);
  localparam int NV_W = $clog2(NV_WR_CYCLES + 1);

  typedef struct packed {
    lro_in_t s1;
    lro_in_t s2;
    lro_in_t prev;
    logic [7:0] nv1;
    logic [7:0] nv2;
    lro_out_t o;
    logic [LRO_IR_NUM-1:0] ir_arm;
    logic [LRO_IR_NUM-1:0] rst_prev;
    lro_pr_state_t pr_st;
    logic [10:0] pr_dur;
    logic [5:0] pr_win;
    logic [2:0] pr_intr;
    logic [TICK_W-1:0] tick_cnt;
    logic tick;
    logic [2:0] blink_cnt;
    logic blink;
    logic [LRO_SR_NUM-1:0] nv_last;
    logic nv_busy;
    logic [NV_W-1:0] nv_cnt;
    logic [16:0] nv_writes;
    logic nv_exh;
    logic nv_req;
    logic [7:0] nv_data;
    logic [1:0] init_cnt;
    lro_ctrl_t ctrl;
    logic [LRO_RETAIN_MAX-1:0] retain;
    lro_mreg_t mreg;
    lro_prcfg_t prcfg;
    logic a_wr;
    logic [11:0] a_addr;
    logic rdy;
    logic [31:0] rdata;
  } lro_st_t;

  lro_st_t st;
  lro_st_t n;
  logic [1:0] gate_in;
  logic [1:0] gate_rst;

  generate
    for (genvar m = 0; m < 2; m++)
    begin : g_mac
      lro_gate #(.N(LRO_GATE_IN), .MIN_CNT(2)) u_in (
        .din(st.s2.m_in[m]),
        .cnt(st.mreg.m[m].in_cnt),
        .gtype(st.mreg.m[m].in_type),
        .dout(gate_in[m])
      );
      lro_gate #(.N(LRO_GATE_IN), .MIN_CNT(1)) u_rst (
        .din(st.s2.m_rst[m]),
        .cnt(st.mreg.m[m].rst_cnt),
        .gtype(st.mreg.m[m].rst_type),
        .dout(gate_rst[m])
      );
    end
  endgenerate

  always_comb
  begin
    logic ck_rise;
    logic [LRO_SR_NUM-1:0] sr_q;
    logic [LRO_SR_NUM-1:0] ret;
    logic [3:0] in_v;
    logic [3:0] rst_v;
    logic [3:0] clr_v;
    logic [3:0] kill;
    logic [3:0] rise;
    logic [3:0] fall;
    logic [3:0] qv;
    logic [3:0] t1;
    logic [3:0] t2;
    logic b1r;
    logic b1f;
    logic b2r;
    logic b2f;
    logic intr_ok;
    logic [6:0] secs;
    logic [10:0] maxt;
    ck_rise = 1'b0;
    sr_q = '0;
    ret = '0;
    in_v = '0;
    rst_v = '0;
    clr_v = '0;
    kill = '0;
    rise = '0;
    fall = '0;
    qv = '0;
    t1 = '0;
    t2 = '0;
    b1r = 1'b0;
    b1f = 1'b0;
    b2r = 1'b0;
    b2f = 1'b0;
    intr_ok = 1'b0;
    secs = '0;
    maxt = '0;
    n = st;

    // Pin synchronisers and previous-cycle samples
    n.s1 = op_in;
    n.s2 = st.s1;
    n.prev = st.s2;
    n.nv1 = nv_rd_data;
    n.nv2 = st.nv1;

    // Shared 100 ms tick and half-second blink
    n.tick = 1'b0;
    n.tick_cnt = st.tick_cnt + 1'b1;
    if (st.tick_cnt == TICK_W'(TICK_CYCLES - 1))
    begin
      n.tick_cnt = '0;
      n.tick = 1'b1;
    end
    if (st.tick)
    begin
      n.blink_cnt = st.blink_cnt + 3'd1;
      if (st.blink_cnt == 3'(LRO_BLINK_TICKS - 1))
      begin
        n.blink_cnt = '0;
        n.blink = ~st.blink;
      end
    end

    // D latch
    ck_rise = st.s2.d_ck & ~st.prev.d_ck;
    if (st.s2.d_clr && st.ctrl.d_clr_en)
    begin
      n.o.d_q = 1'b0;
    end
    else if (st.s2.d_pre && st.ctrl.d_pre_en)
    begin
      n.o.d_q = 1'b1;
    end
    else if (ck_rise)
    begin
      n.o.d_q = st.s2.d_smp;
    end

    // Toggle latch
    if (st.s2.t_clr && st.ctrl.t_clr_en)
    begin
      n.o.t_q = 1'b0;
    end
    else if (st.s2.t_tgl && !st.prev.t_tgl)
    begin
      n.o.t_q = ~st.o.t_q;
    end

    // Set/reset latches, reset dominant
    sr_q = (st.o.sr_q | st.s2.sr_set) & ~st.s2.sr_rst;
    sr_q = sr_q & ~(st.s2.sr_clr & {LRO_SR_NUM{st.ctrl.sr_clr_en}});
    ret = st.retain[LRO_SR_NUM-1:0];
    if (st.init_cnt != 2'd3)
    begin
      n.init_cnt = st.init_cnt + 2'd1;
    end
    // Restore once the stored image has passed the synchroniser
    if (st.init_cnt == 2'd2)
    begin
      sr_q = (st.nv2[LRO_SR_NUM-1:0] & ret) | (sr_q & ~ret);
      n.nv_last = sr_q & ret;
    end
    n.o.sr_q = sr_q;

    // Storage writes coalesce changes made while a write is in flight
    if (st.nv_busy)
    begin
      n.nv_cnt = st.nv_cnt + 1'b1;
      if (st.nv_cnt == NV_W'(NV_WR_CYCLES - 1))
      begin
        n.nv_busy = 1'b0;
        n.nv_req = 1'b0;
      end
    end
    else if (st.init_cnt == 2'd3 && !st.nv_exh && ((st.o.sr_q & ret) != st.nv_last))
    begin
      n.nv_busy = 1'b1;
      n.nv_req = 1'b1;
      n.nv_cnt = '0;
      n.nv_last = st.o.sr_q & ret;
      n.nv_data = 8'(st.o.sr_q & ret);
      n.nv_writes = st.nv_writes + 17'd1;
    end
    n.nv_exh = (n.nv_writes == 17'(LRO_NV_WR_LIMIT));

    // Restart interlocks: 0 manual, 1 monitored, 2 macro manual, 3 macro monitored
    in_v = {gate_in[1], gate_in[0], st.s2.ir_in};
    rst_v = {gate_rst[1], gate_rst[0], st.s2.ir_rst};
    clr_v = st.s2.ir_clr & st.ctrl.ir_clr_en;
    n.rst_prev = rst_v;
    rise = rst_v & ~st.rst_prev;
    fall = ~rst_v & st.rst_prev;
    kill = clr_v | ~in_v;
    n.ir_arm = ~kill & LRO_IR_MONITORED & (rise | (st.ir_arm & ~fall));
    qv = ~kill & (st.o.ir_q | (~LRO_IR_MONITORED & rise) | (LRO_IR_MONITORED & fall & st.ir_arm));
    n.o.ir_q = qv;
    t1 = ~kill & ~qv;
    t2 = kill | (~qv & {4{st.blink}});
    n.o.ir_req = st.ctrl.ir_req_en & ((st.ctrl.ir_style2 & t2) | (~st.ctrl.ir_style2 & t1));
    n.o.m_gate = gate_in & {st.ctrl.m2_out_en, st.ctrl.m1_out_en};

    // Pre-reset sequencer, timed in ticks
    b1r = st.s2.pr_b1 & ~st.prev.pr_b1;
    b1f = ~st.s2.pr_b1 & st.prev.pr_b1;
    b2r = st.s2.pr_b2 & ~st.prev.pr_b2;
    b2f = ~st.s2.pr_b2 & st.prev.pr_b2;
    secs = st.prcfg.max_s;
    if (secs < 7'(LRO_PULSE_MIN_S))
    begin
      secs = 7'(LRO_PULSE_MIN_S);
    end
    else if (secs > 7'(LRO_PULSE_MAX_S))
    begin
      secs = 7'(LRO_PULSE_MAX_S);
    end
    maxt = 11'(secs * LRO_TICKS_PER_S);
    intr_ok = !st.ctrl.pr_intr_en || (st.pr_intr != 3'd0 && st.pr_intr < st.prcfg.intr_lim);
    case (st.pr_st)
      LRO_PR_IDLE:
      begin
        if (b1r)
        begin
          n.pr_st = LRO_PR_B1;
          n.pr_dur = '0;
          n.pr_intr = '0;
        end
      end
      LRO_PR_B1:
      begin
        if (st.tick)
        begin
          n.pr_dur = st.pr_dur + 11'd1;
        end
        if (st.pr_dur >= maxt)
        begin
          n.pr_st = LRO_PR_IDLE;
        end
        else if (b1f)
        begin
          n.pr_st = LRO_PR_WAIT;
          n.pr_win = '0;
        end
      end
      LRO_PR_WAIT:
      begin
        if (st.tick)
        begin
          n.pr_win = st.pr_win + 6'd1;
        end
        if (st.pr_win >= 6'(LRO_WIN_MAX_TICKS))
        begin
          n.pr_st = LRO_PR_IDLE;
        end
        else if (b1r)
        begin
          n.pr_st = LRO_PR_B1;
          if (st.ctrl.pr_intr_en)
          begin
            // A low gap inside the first pulse is an interruption
            if (st.pr_intr != 3'd7)
            begin
              n.pr_intr = st.pr_intr + 3'd1;
            end
          end
          else
          begin
            n.pr_dur = '0;
            n.pr_intr = '0;
          end
        end
        else if (b2r)
        begin
          n.pr_st = LRO_PR_B2;
          n.pr_dur = '0;
        end
      end
      LRO_PR_B2:
      begin
        if (st.tick)
        begin
          n.pr_win = st.pr_win + 6'd1;
          n.pr_dur = st.pr_dur + 11'd1;
        end
        if (st.pr_dur >= maxt || st.pr_win >= 6'(LRO_WIN_MAX_TICKS))
        begin
          n.pr_st = LRO_PR_IDLE;
        end
        else if (b2f)
        begin
          if (st.pr_win >= 6'(LRO_WIN_MIN_TICKS) && intr_ok)
          begin
            n.pr_st = LRO_PR_DONE;
          end
          else
          begin
            n.pr_st = LRO_PR_IDLE;
          end
        end
      end
      LRO_PR_DONE:
      begin
        n.pr_st = LRO_PR_DONE;
      end
      default:
      begin
        n.pr_st = LRO_PR_IDLE;
      end
    endcase
    if (st.s2.pr_clr && st.ctrl.pr_clr_en)
    begin
      n.pr_st = LRO_PR_IDLE;
    end
    n.o.pr_q = (n.pr_st == LRO_PR_DONE);
    n.o.pr_wait = st.ctrl.pr_wait_en && (n.pr_st == LRO_PR_WAIT || n.pr_st == LRO_PR_B2);

    // AHB-Lite data phase writes; reserved bits kept at zero
    if (st.a_wr)
    begin
      case (st.a_addr)
        LRO_OFS_CTRL:
        begin
          n.ctrl = lro_ctrl_t'(hwdata);
          n.ctrl.rsvd = '0;
        end
        LRO_OFS_RETAIN: n.retain = hwdata[LRO_RETAIN_MAX-1:0];
        LRO_OFS_MACRO:
        begin
          n.mreg = lro_mreg_t'(hwdata);
          n.mreg.rsvd = '0;
        end
        LRO_OFS_PRE:
        begin
          n.prcfg = lro_prcfg_t'(hwdata);
          n.prcfg.rsvd = '0;
          n.prcfg.rsvd_b = 1'b0;
        end
        default: n.a_wr = 1'b0;
      endcase
    end
    // Address phase; read data is registered here, so no wait states
    n.a_wr = 1'b0;
    if (hsel && hready && htrans[1])
    begin
      n.a_wr = hwrite;
      n.a_addr = haddr[11:0];
      if (!hwrite)
      begin
        case (haddr[11:0])
          LRO_OFS_CTRL: n.rdata = 32'(st.ctrl);
          LRO_OFS_RETAIN: n.rdata = 32'(st.retain);
          LRO_OFS_MACRO: n.rdata = 32'(st.mreg);
          LRO_OFS_PRE: n.rdata = 32'(st.prcfg);
          LRO_OFS_STATUS: n.rdata = 32'({st.pr_st, st.o});
          LRO_OFS_NV: n.rdata = 32'({st.nv_exh, st.nv_busy, st.nv_writes});
          default: n.rdata = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st <= '0;
      st.rdy <= 1'b1;
      st.ctrl <= LRO_CTRL_RST;
      st.mreg <= LRO_MACRO_RST;
      st.prcfg <= LRO_PRE_RST;
      st.retain <= RETAIN_INIT;
    end
    else
    begin
      st <= n;
    end
  end

  assign hreadyout = st.rdy;
  assign hresp = 1'b0;
  assign hrdata = st.rdata;
  assign op_out = st.o;
  assign nv_wr_req = st.nv_req;
  assign nv_wr_data = st.nv_data;

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_d_clr;
    (st.s2.d_clr && st.ctrl.d_clr_en) |=> !op_out.d_q;
  endproperty
  a_d_clr: assert property (p_d_clr) else $error("D latch not cleared");
  property p_pre_off;
    (st.s2.d_pre && !st.ctrl.d_pre_en && !st.s2.d_clr && !(st.s2.d_ck && !st.prev.d_ck)) |=> $stable(op_out.d_q);
  endproperty
  a_pre_off: assert property (p_pre_off) else $error("Disabled preset changed D latch");
  property p_toggle;
    (st.s2.t_tgl && !st.prev.t_tgl && !(st.s2.t_clr && st.ctrl.t_clr_en)) |=> op_out.t_q != $past(op_out.t_q);
  endproperty
  a_toggle: assert property (p_toggle) else $error("Toggle latch did not invert");
  property p_sr_both;
    (st.s2.sr_set[1] && st.s2.sr_rst[1] && st.init_cnt == 2'd3) |=> !op_out.sr_q[1];
  endproperty
  a_sr_both: assert property (p_sr_both) else $error("Set/reset latch not reset dominant");
  property p_ir_in_low;
    !st.s2.ir_in[0] |=> !op_out.ir_q[0];
  endproperty
  a_ir_in_low: assert property (p_ir_in_low) else $error("Interlock high with input low");
  property p_mon_rise;
    (st.s2.ir_rst[1] && !st.rst_prev[1]) |=> !$rose(op_out.ir_q[1]);
  endproperty
  a_mon_rise: assert property (p_mon_rise) else $error("Monitored interlock set on rise");
  property p_req1;
    ($past(st.ctrl.ir_req_en[0]) && !$past(st.ctrl.ir_style2[0]) && op_out.ir_q[0]) |-> !op_out.ir_req[0];
  endproperty
  a_req1: assert property (p_req1) else $error("Style one request high after restart");
  property p_wait;
    op_out.pr_wait |-> (st.pr_st == LRO_PR_WAIT || st.pr_st == LRO_PR_B2);
  endproperty
  a_wait: assert property (p_wait) else $error("Waiting output outside waiting states");
  property p_pr_set;
    $rose(op_out.pr_q) |-> ($past(st.pr_st) == LRO_PR_B2 && $past(st.pr_win) >= 6'(LRO_WIN_MIN_TICKS));
  endproperty
  a_pr_set: assert property (p_pr_set) else $error("Pre-reset set outside window");
  property p_intr;
    ($rose(op_out.pr_q) && $past(st.ctrl.pr_intr_en)) |-> ($past(st.pr_intr) != 3'd0
      && $past(st.pr_intr) < $past(st.prcfg.intr_lim));
  endproperty
  a_intr: assert property (p_intr) else $error("Pre-reset set with bad interruption count");
  property p_dur;
    st.pr_dur <= 11'(LRO_PULSE_MAX_S * LRO_TICKS_PER_S);
  endproperty
  a_dur: assert property (p_dur) else $error("Pulse timer beyond maximum");
  property p_nv_budget;
    $rose(st.nv_busy) |-> ($past(st.nv_writes) < 17'(LRO_NV_WR_LIMIT) && st.nv_cnt == '0);
  endproperty
  a_nv_budget: assert property (p_nv_budget) else $error("Storage write beyond budget");
  property p_gate_off;
    !$past(st.ctrl.m1_out_en) |-> !op_out.m_gate[0];
  endproperty
  a_gate_off: assert property (p_gate_off) else $error("Gate result shown while disabled");

endmodule

// file: verif/lro_nv_model.sv
`timescale 1ns/10ps
module lro_nv_model
  import lro_pkg::*;
#(
  parameter logic [7:0] INIT = 8'h01
)(
  // Clock
  hclk,
  // Store port
  nv_wr_req,
  nv_wr_data,
  nv_rd_data
);
  input wire logic hclk;
  input wire logic nv_wr_req;
  input wire logic [7:0] nv_wr_data;
  output wire logic [7:0] nv_rd_data;

  // Image seen at power-up
  logic [7:0] img = INIT;

  assign nv_rd_data = img;

  // Store takes the image while a write request stands
  always @(posedge hclk)
  begin
    if (nv_wr_req === 1'b1)
      img <= nv_wr_data;
  end
endmodule

// file: verif/tb.sv
`timescale 1ns/10ps
module tb
  import lro_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, nv_req;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [7:0] nv_rd, nv_wdat;
  logic [5:0] gexp = 6'h16;
  lro_in_t op_in;
  lro_out_t op_out;
  int fail_count = 0;
  int num_checks = 0;

  lro_ops #(.TICK_CYCLES(10), .NV_WR_CYCLES(8), .RETAIN_INIT(8'h01)) lro_ops_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .op_in(op_in),
    .op_out(op_out), .nv_rd_data(nv_rd), .nv_wr_req(nv_req), .nv_wr_data(nv_wdat));

  lro_nv_model #(.INIT(8'h01)) lro_nv_model_i (
    .hclk(hclk), .nv_wr_req(nv_req), .nv_wr_data(nv_wdat), .nv_rd_data(nv_rd));

  initial
  begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Single word transfer; read data lands in rd
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {20'h0_0000, a};
    hwrite <= w;
    htrans <= 2'b10;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
    chk("hresp", 32'h0, 32'(hresp));
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Whole sequence needs about 1400 cycles
  initial
  begin
    cyc(20000);
    fail_count++;
    end_sim();
  end

  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    op_in = '0;
    cyc(4);
    hresetn <= 1'b1;
    cyc(4);
    bus(1'b0, LRO_OFS_CTRL, 32'h0);
    chk("ctrl", 32'h0, rd);
    bus(1'b0, LRO_OFS_MACRO, 32'h0);
    chk("macro", 32'h0004_2042, rd);
    bus(1'b0, LRO_OFS_PRE, 32'h0);
    chk("pre", 32'h0000_0778, rd);
    bus(1'b1, 12'h100, 32'hffff_ffff);
    bus(1'b0, 12'h100, 32'h0);
    chk("unmapped", 32'h0, rd);
    chk("restore", 32'h1, 32'(op_out.sr_q[0]));
    $display("registers done");
    op_in.d_pre <= 1'b1;
    cyc(5);
    chk("d_q", 32'h0, 32'(op_out.d_q));
    bus(1'b1, LRO_OFS_CTRL, 32'h000b_011f);
    cyc(5);
    chk("d_q", 32'h1, 32'(op_out.d_q));
    op_in.d_clr <= 1'b1;
    cyc(5);
    chk("d_q", 32'h0, 32'(op_out.d_q));
    op_in.d_pre <= 1'b0;
    op_in.d_clr <= 1'b0;
    op_in.d_smp <= 1'b1;
    op_in.d_ck <= 1'b1;
    cyc(5);
    chk("d_q", 32'h1, 32'(op_out.d_q));
    op_in.d_smp <= 1'b0;
    cyc(5);
    chk("d_q", 32'h1, 32'(op_out.d_q));
    op_in.d_ck <= 1'b0;
    cyc(3);
    op_in.d_ck <= 1'b1;
    cyc(5);
    chk("d_q", 32'h0, 32'(op_out.d_q));
    $display("d latch done");
    for (int i = 0; i < 3; i++)
    begin
      op_in.t_tgl <= 1'b1;
      cyc(5);
      chk("t_q", 32'(i % 2 == 0), 32'(op_out.t_q));
      op_in.t_tgl <= 1'b0;
      cyc(5);
      chk("t_q", 32'(i % 2 == 0), 32'(op_out.t_q));
    end
    op_in.t_clr <= 1'b1;
    cyc(5);
    chk("t_q", 32'h0, 32'(op_out.t_q));
    $display("toggle done");
    op_in.sr_set[1] <= 1'b1;
    cyc(5);
    chk("sr_q1", 32'h1, 32'(op_out.sr_q[1]));
    op_in.sr_set[1] <= 1'b0;
    cyc(5);
    chk("sr_q1", 32'h1, 32'(op_out.sr_q[1]));
    op_in.sr_clr[1] <= 1'b1;
    cyc(5);
    chk("sr_q1", 32'h0, 32'(op_out.sr_q[1]));
    op_in.sr_clr[1] <= 1'b0;
    op_in.sr_set[1] <= 1'b1;
    op_in.sr_rst[1] <= 1'b1;
    cyc(5);
    chk("sr_q1", 32'h0, 32'(op_out.sr_q[1]));
    bus(1'b1, LRO_OFS_RETAIN, 32'h1);
    cyc(30);
    op_in.sr_rst[0] <= 1'b1;
    cyc(5);
    chk("sr_q0", 32'h0, 32'(op_out.sr_q[0]));
    cyc(30);
    chk("nv image", 32'h0, 32'(nv_rd));
    $display("set reset done");
    op_in.ir_in[0] <= 1'b1;
    cyc(5);
    chk("ir_q0", 32'h0, 32'(op_out.ir_q[0]));
    chk("ir_req0", 32'h1, 32'(op_out.ir_req[0]));
    op_in.ir_rst[0] <= 1'b1;
    cyc(5);
    chk("ir_q0", 32'h1, 32'(op_out.ir_q[0]));
    chk("ir_req0", 32'h0, 32'(op_out.ir_req[0]));
    op_in.ir_in[0] <= 1'b0;
    cyc(5);
    chk("ir_q0", 32'h0, 32'(op_out.ir_q[0]));
    op_in.ir_in[1] <= 1'b1;
    op_in.ir_rst[1] <= 1'b1;
    cyc(5);
    chk("ir_q1", 32'h0, 32'(op_out.ir_q[1]));
    op_in.ir_rst[1] <= 1'b0;
    cyc(5);
    chk("ir_q1", 32'h1, 32'(op_out.ir_q[1]));
    bus(1'b1, LRO_OFS_CTRL, 32'h000b_111f);
    cyc(5);
    chk("ir_req0", 32'h1, 32'(op_out.ir_req[0]));
    op_in.ir_in[0] <= 1'b1;
    op_in.ir_rst[0] <= 1'b0;
    cyc(5);
    // Half a blink period apart the request shows opposite levels
    rd = 32'(op_out.ir_req[0]);
    cyc(50);
    chk("ir_req0", rd ^ 32'h1, 32'(op_out.ir_req[0]));
    op_in.ir_rst[0] <= 1'b1;
    cyc(5);
    chk("ir_q0", 32'h1, 32'(op_out.ir_q[0]));
    chk("ir_req0", 32'h0, 32'(op_out.ir_req[0]));
    $display("interlock done");
    op_in.m_in[0] <= 7'h01;
    for (int g = 0; g < 6; g++)
    begin
      bus(1'b1, LRO_OFS_MACRO, 32'h0004_2042 | (32'(g) << 3));
      cyc(5);
      chk("m_gate0", 32'(gexp[g]), 32'(op_out.m_gate[0]));
    end
    // NAND restart gate: a missing bypass would invert the single input
    bus(1'b1, LRO_OFS_MACRO, 32'h0004_2242);
    op_in.m_in[0] <= 7'h03;
    // Only bit 0 counts when the restart gate is bypassed
    op_in.m_rst[0] <= 7'h7e;
    cyc(5);
    chk("ir_q2", 32'h0, 32'(op_out.ir_q[2]));
    op_in.m_rst[0] <= 7'h01;
    cyc(5);
    chk("ir_q2", 32'h1, 32'(op_out.ir_q[2]));
    $display("macro done");
    op_in.pr_b1 <= 1'b1;
    cyc(20);
    op_in.pr_b1 <= 1'b0;
    cyc(10);
    chk("pr_wait", 32'h1, 32'(op_out.pr_wait));
    cyc(80);
    op_in.pr_b2 <= 1'b1;
    cyc(20);
    op_in.pr_b2 <= 1'b0;
    cyc(10);
    chk("pr_q", 32'h1, 32'(op_out.pr_q));
    op_in.pr_clr <= 1'b1;
    cyc(5);
    chk("pr_q", 32'h0, 32'(op_out.pr_q));
    op_in.pr_clr <= 1'b0;
    op_in.pr_b1 <= 1'b1;
    cyc(20);
    op_in.pr_b1 <= 1'b0;
    cyc(5);
    op_in.pr_b2 <= 1'b1;
    cyc(10);
    op_in.pr_b2 <= 1'b0;
    cyc(10);
    chk("pr_q", 32'h0, 32'(op_out.pr_q));
    op_in.pr_b1 <= 1'b1;
    cyc(20);
    op_in.pr_b1 <= 1'b0;
    cyc(10);
    chk("pr_wait", 32'h1, 32'(op_out.pr_wait));
    // Window runs out with no second button
    cyc(600);
    chk("pr_wait", 32'h0, 32'(op_out.pr_wait));
    $display("pre-reset done");
    bus(1'b1, LRO_OFS_CTRL, 32'h000f_111f);
    for (int r = 0; r < 2; r++)
    begin
      op_in.pr_clr <= 1'b1;
      cyc(5);
      op_in.pr_clr <= 1'b0;
      for (int k = 0; k < 2 - r; k++)
      begin
        op_in.pr_b1 <= 1'b1;
        cyc(10);
        op_in.pr_b1 <= 1'b0;
        cyc(10);
      end
      cyc(50);
      op_in.pr_b2 <= 1'b1;
      cyc(20);
      op_in.pr_b2 <= 1'b0;
      cyc(10);
      chk("pr_q", 32'(r == 0), 32'(op_out.pr_q));
    end
    $display("interruptions done");
    end_sim();
  end
endmodule
